// *** dual_timer_counter_unit.sv ***
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Summary of operation
// - One shared 10-bit prescaler gives CK/8, /64, /256, /1024 taps to both counters.
// - Narrow clock select: stop, CK, four taps, external falling, external rising.
// - External clock pin advances the counter even when configured as an output.
// - External count clock is sampled on the rising system clock edge.
// - Narrow counter counts up, is read/write, resumes after a write.
// - Narrow control upper five bits are read-only zero.
// - Narrow overflow sets a shared flag; the shared mask register only stores its bit and gates nothing.
// - Wide counter has the same clock choices as the narrow one.
// - Wide overflow, compare and capture flags sit in the shared flag register.
// - Wide counter is compared continuously against compare A and B.
// - Compare A match may clear the counter; matches act on output pins.
// - PWM mode gives dual glitch-free centred PWM of 8, 9 or 10 bits.
// - Capture pin event copies the wide counter into the capture register.
// - Capture pin feeds the noise canceller permanently.
// - With filtering on, four matching samples are needed before capture.
// - Compare action field: off, toggle, clear, set on a match.
// - Compare pin is driven only when its direction bit selects output.
// - In PWM mode the compare action field has PWM meaning.
// - PWM select: off, 8-bit, 9-bit, 10-bit.
// - Clear-on-match zeroes the counter the cycle after compare A match, only when PWM mode is off.
// - Sixteen-bit access via shared byte latch: write high first, read low first.
// - Edge select zero captures falling edge, one captures rising edge.
module dual_timer_counter_unit (
   input  wire logic               clk_sys_i,
   input  wire logic               rst_i,
   input  wire timer_pkg::axi_req_t axi_req_i,
   output timer_pkg::axi_rsp_t     axi_rsp_o,
   input  wire logic               narrow_ext_clock_pin_i,
   input  wire logic               wide_ext_clock_pin_i,
   input  wire logic               capture_pin_i,
   output logic                    compare_a_pin_o,
   output logic                    compare_a_pin_oe_o,
   output logic                    compare_b_pin_o,
   output logic                    compare_b_pin_oe_o
);
   import timer_pkg::*;

   state_t      s_reg;
   state_t      s_next;
   logic [4:0]  div_tick;
   logic [2:0]  agree;
   logic [2:0]  rise;
   logic [2:0]  fall;
   logic        tick0;
   logic        tick1;
   logic        pwm_on;
   logic [15:0] top;
   logic        match_a;
   logic        match_b;
   logic        qual;
   logic        cap_evt;
   logic        do_write;
   logic        mapped;
   logic [7:0]  set_f;
   logic [7:0]  clr_f;
   logic [7:0]  rbyte;
   logic [5:0]  ridx;

   // ==========================================================
   // Helpers
   function automatic logic sel_tick(input logic [2:0] cs, input logic [4:0] dt,
                                     input logic r, input logic f);
      logic t;
      t = 1'b0;

      case (cs)
         CS_STOP:     t = 1'b0;
         CS_CK:       t = dt[0];
         CS_DIV8:     t = dt[1];
         CS_DIV64:    t = dt[2];
         CS_DIV256:   t = dt[3];
         CS_DIV1024:  t = dt[4];
         CS_EXT_FALL: t = f;
         CS_EXT_RISE: t = r;
         default:     t = 1'b0;
      endcase
      return t;
   endfunction

   function automatic logic pin_act(input logic [1:0] com, input logic pwm,
                                    input logic down, input logic old);
      logic v;
      v = old;

      if (pwm) begin
         // Non-inverted clears on the way up, inverted sets on the way up
         if (com == COM_CLEAR) begin
            v = down;
         end else if (com == COM_SET) begin
            v = ~down;
         end
      end else begin
         case (com)
            COM_OFF:    v = old;
            COM_TOGGLE: v = ~old;
            COM_CLEAR:  v = 1'b0;
            COM_SET:    v = 1'b1;
            default:    v = old;
         endcase
      end
      return v;
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      logic m;
      m = 1'b0;
      case (idx)
         IDX_CAPTURE_LO: m = 1'b1;
         IDX_CAPTURE_HI: m = 1'b1;
         IDX_CMP_B_LO:   m = 1'b1;
         IDX_CMP_B_HI:   m = 1'b1;
         IDX_CMP_A_LO:   m = 1'b1;
         IDX_CMP_A_HI:   m = 1'b1;
         IDX_WCNT_LO:    m = 1'b1;
         IDX_WCNT_HI:    m = 1'b1;
         IDX_WCTL_B:     m = 1'b1;
         IDX_WCTL_A:     m = 1'b1;
         IDX_PIN_DIR:    m = 1'b1;
         IDX_NCNT:       m = 1'b1;
         IDX_NCTL:       m = 1'b1;
         IDX_FLAG:       m = 1'b1;
         IDX_MASK:       m = 1'b1;
         // Gaps in the map answer with an error
         default:        m = 1'b0;
      endcase
      return m;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      s_next = s_reg;
      set_f  = 8'h00;
      clr_f  = 8'h00;
      rbyte  = 8'h00;
      ridx   = axi_req_i.araddr[7:2];

      // Free-running prescaler, taps shared by both counters
      s_next.psc  = s_reg.psc + 1'b1;

      div_tick[0] = 1'b1;
      div_tick[1] = &s_reg.psc[2:0];
      div_tick[2] = &s_reg.psc[5:0];
      div_tick[3] = &s_reg.psc[7:0];
      div_tick[4] = &s_reg.psc[PSC_W-1:0];

      // Pads taken straight, so an output-configured pin still counts
      s_next.sync1 = {capture_pin_i, wide_ext_clock_pin_i, narrow_ext_clock_pin_i};
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;

      agree        = ~(s_reg.sync2 ^ s_reg.sync3);
      s_next.lvl   = (agree & s_reg.sync2) | (~agree & s_reg.lvl);

      rise         = s_next.lvl & ~s_reg.lvl;
      fall         = ~s_next.lvl & s_reg.lvl;

      tick0 = sel_tick(s_reg.nctl[2:0], div_tick, rise[PIN_NARROW],
                       fall[PIN_NARROW]);

      tick1 = sel_tick(s_reg.wctl_b[2:0], div_tick, rise[PIN_WIDE],
                       fall[PIN_WIDE]);

      // ==========================================================
      // Narrow counter
      if (tick0) begin
         s_next.ncnt = s_reg.ncnt + 8'h01;
         if (s_reg.ncnt == NARROW_MAX) begin
            set_f[FLAG_NARROW_OVF] = 1'b1;
         end
      end

      // ==========================================================
      // Wide counter
      case (s_reg.wctl_a[1:0])
         PWM_OFF: top = WIDE_MAX;
         PWM_8:   top = TOP_8;
         PWM_9:   top = TOP_9;
         default: top = TOP_10;
      endcase

      pwm_on  = s_reg.wctl_a[1:0] != PWM_OFF;

      // Match seen only in the cycle right after the counter moves onto the value
      match_a = s_reg.moved && s_reg.wcnt == s_reg.act_a;
      match_b = s_reg.moved && s_reg.wcnt == s_reg.act_b;

      s_next.moved = 1'b0;
      if (match_a && s_reg.wctl_b[CTLB_CLEAR] && !pwm_on) begin
         s_next.wcnt  = 16'h0000;
         s_next.moved = 1'b1;
      end else if (tick1) begin
         s_next.moved = 1'b1;
         if (!pwm_on) begin
            s_next.wcnt = s_reg.wcnt + 16'h0001;
            if (s_reg.wcnt == WIDE_MAX) begin
               set_f[FLAG_WIDE_OVF] = 1'b1;
            end
         end else if (!s_reg.down) begin
            if (s_reg.wcnt >= top) begin
               s_next.down = 1'b1;
               s_next.wcnt = top - 16'h0001;
            end else begin
               s_next.wcnt = s_reg.wcnt + 16'h0001;
            end
         end else if (s_reg.wcnt == 16'h0000) begin
            s_next.down = 1'b0;
            s_next.wcnt = 16'h0001;
            set_f[FLAG_WIDE_OVF] = 1'b1;
         end else begin
            s_next.wcnt = s_reg.wcnt - 16'h0001;
         end
      end

      if (!pwm_on) begin
         s_next.down = 1'b0;
      end

      // In PWM mode compare copies move only at top, so a pulse never splits; otherwise they follow every cycle
      if (!pwm_on || s_reg.wcnt == top) begin
         s_next.act_a = s_reg.cmp_a;
         s_next.act_b = s_reg.cmp_b;
      end

      if (match_a) begin
         set_f[FLAG_CMP_A] = 1'b1;
         s_next.out_a = pin_act(s_reg.wctl_a[7:6], pwm_on, s_reg.down, s_reg.out_a);
      end

      if (match_b) begin
         set_f[FLAG_CMP_B] = 1'b1;
         s_next.out_b = pin_act(s_reg.wctl_a[5:4], pwm_on, s_reg.down, s_reg.out_b);
      end

      s_next.drive_a = s_reg.pin_dir[DIR_A] && s_reg.wctl_a[7:6] != COM_OFF &&
                       !(pwm_on && s_reg.wctl_a[7:6] == COM_TOGGLE);

      s_next.drive_b = s_reg.pin_dir[DIR_B] && s_reg.wctl_a[5:4] != COM_OFF &&
                       !(pwm_on && s_reg.wctl_a[5:4] == COM_TOGGLE);

      // ==========================================================
      // Capture with optional four-sample canceller
      s_next.hist = {s_reg.hist[FILTER_LEN-2:0], s_next.lvl[PIN_CAPTURE]};
      qual = s_reg.wctl_b[CTLB_EDGE] ? &s_next.hist : ~|s_next.hist;
      s_next.cap_cond = qual;

      if (s_reg.wctl_b[CTLB_FILTER]) begin
         cap_evt = qual && !s_reg.cap_cond;
      end else begin
         cap_evt = s_reg.wctl_b[CTLB_EDGE] ? rise[PIN_CAPTURE] : fall[PIN_CAPTURE];
      end

      if (cap_evt) begin
         s_next.cap = s_reg.wcnt;
         set_f[FLAG_CAPTURE] = 1'b1;
      end

      // ==========================================================
      // Bus write side, address and data in either order
      if (axi_req_i.awvalid && s_reg.rsp.awready) begin
         s_next.aw_full = 1'b1;
         s_next.aw_idx  = axi_req_i.awaddr[7:2];
      end

      if (axi_req_i.wvalid && s_reg.rsp.wready) begin
         s_next.w_full = 1'b1;
         s_next.wbyte  = axi_req_i.wdata[7:0];
         s_next.wlane  = axi_req_i.wstrb[0];
      end

      if (s_reg.rsp.bvalid && axi_req_i.bready) begin
         s_next.rsp.bvalid = 1'b0;
      end

      do_write = s_reg.aw_full && s_reg.w_full && !s_reg.rsp.bvalid;
      mapped   = is_mapped(s_reg.aw_idx);

      if (do_write) begin
         s_next.aw_full    = 1'b0;
         s_next.w_full     = 1'b0;
         s_next.rsp.bvalid = 1'b1;
         s_next.rsp.bresp  = mapped ? RESP_OKAY : RESP_SLVERR;
         if (s_reg.wlane) begin
            case (s_reg.aw_idx)
               IDX_NCTL:   s_next.nctl = s_reg.wbyte & NCTL_WMASK;
               IDX_NCNT:   s_next.ncnt = s_reg.wbyte;
               IDX_WCTL_A: s_next.wctl_a = s_reg.wbyte & WCTLA_WMASK;
               IDX_WCTL_B: s_next.wctl_b = s_reg.wbyte & WCTLB_WMASK;
               IDX_WCNT_HI, IDX_CMP_A_HI, IDX_CMP_B_HI: s_next.temp = s_reg.wbyte;
               IDX_WCNT_LO: begin
                  s_next.wcnt  = {s_reg.temp, s_reg.wbyte};
                  s_next.moved = 1'b0;
               end
               IDX_CMP_A_LO: s_next.cmp_a = {s_reg.temp, s_reg.wbyte};
               IDX_CMP_B_LO: s_next.cmp_b = {s_reg.temp, s_reg.wbyte};
               IDX_FLAG:    clr_f = s_reg.wbyte & FLAG_MASK;
               IDX_MASK:    s_next.mask = s_reg.wbyte & FLAG_MASK;
               IDX_PIN_DIR: s_next.pin_dir = s_reg.wbyte & DIR_MASK;
               default: ;
            endcase
         end
      end

      // A hardware event beats a clear in the same cycle
      s_next.flags = (s_reg.flags & ~clr_f) | set_f;

      // ==========================================================
      // Bus read side, low byte read loads the latch
      if (s_reg.rsp.rvalid && axi_req_i.rready) begin
         s_next.rsp.rvalid = 1'b0;
      end

      if (axi_req_i.arvalid && s_reg.rsp.arready) begin
         case (ridx)
            IDX_NCTL:   rbyte = s_reg.nctl;
            IDX_NCNT:   rbyte = s_reg.ncnt;
            IDX_WCTL_A: rbyte = s_reg.wctl_a;
            IDX_WCTL_B: rbyte = s_reg.wctl_b;
            IDX_WCNT_HI, IDX_CMP_A_HI, IDX_CMP_B_HI, IDX_CAPTURE_HI: rbyte = s_reg.temp;
            IDX_WCNT_LO: begin
               rbyte       = s_reg.wcnt[7:0];
               s_next.temp = s_reg.wcnt[15:8];
            end
            IDX_CMP_A_LO: begin
               rbyte       = s_reg.cmp_a[7:0];
               s_next.temp = s_reg.cmp_a[15:8];
            end
            IDX_CMP_B_LO: begin
               rbyte       = s_reg.cmp_b[7:0];
               s_next.temp = s_reg.cmp_b[15:8];
            end
            IDX_CAPTURE_LO: begin
               rbyte       = s_reg.cap[7:0];
               s_next.temp = s_reg.cap[15:8];
            end
            IDX_FLAG:    rbyte = s_reg.flags;
            IDX_MASK:    rbyte = s_reg.mask;
            IDX_PIN_DIR: rbyte = s_reg.pin_dir;
            default:     rbyte = 8'h00;
         endcase

         s_next.rsp.rvalid = 1'b1;
         s_next.rsp.rdata  = {24'h00_0000, rbyte};
         s_next.rsp.rresp  = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      end

      // One transfer in flight per direction keeps the slave simple
      s_next.rsp.awready = !s_next.aw_full && !s_next.rsp.bvalid && !do_write;
      s_next.rsp.wready  = !s_next.w_full && !s_next.rsp.bvalid && !do_write;
      s_next.rsp.arready = !s_next.rsp.rvalid;
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign axi_rsp_o          = s_reg.rsp;
   assign compare_a_pin_o    = s_reg.out_a;
   assign compare_a_pin_oe_o = s_reg.drive_a;
   assign compare_b_pin_o    = s_reg.out_b;
   assign compare_b_pin_oe_o = s_reg.drive_b;

endmodule // dual_timer_counter_unit

// *** timer_pkg.sv ***
package timer_pkg;

   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [5:0] IDX_CAPTURE_LO = 6'h26;
   localparam logic [5:0] IDX_CAPTURE_HI = 6'h27;
   localparam logic [5:0] IDX_CMP_B_LO   = 6'h28;
   localparam logic [5:0] IDX_CMP_B_HI   = 6'h29;
   localparam logic [5:0] IDX_CMP_A_LO   = 6'h2A;
   localparam logic [5:0] IDX_CMP_A_HI   = 6'h2B;
   localparam logic [5:0] IDX_WCNT_LO    = 6'h2C;
   localparam logic [5:0] IDX_WCNT_HI    = 6'h2D;
   localparam logic [5:0] IDX_WCTL_B     = 6'h2E;
   localparam logic [5:0] IDX_WCTL_A     = 6'h2F;
   localparam logic [5:0] IDX_PIN_DIR    = 6'h30;
   localparam logic [5:0] IDX_NCNT       = 6'h32;
   localparam logic [5:0] IDX_NCTL       = 6'h33;
   localparam logic [5:0] IDX_FLAG       = 6'h38;
   localparam logic [5:0] IDX_MASK       = 6'h39;

   // ==========================================================
   // Field positions and write masks
   localparam int FLAG_NARROW_OVF = 0;
   localparam int FLAG_CAPTURE    = 3;
   localparam int FLAG_CMP_B      = 5;
   localparam int FLAG_CMP_A      = 6;
   localparam int FLAG_WIDE_OVF   = 7;
   localparam int CTLB_FILTER     = 7;
   localparam int CTLB_EDGE       = 6;
   localparam int CTLB_CLEAR      = 3;
   localparam int DIR_A           = 0;
   localparam int DIR_B           = 1;
   localparam int PIN_NARROW      = 0;
   localparam int PIN_WIDE        = 1;
   localparam int PIN_CAPTURE     = 2;
   localparam logic [7:0] NCTL_WMASK = 8'h07;
   localparam logic [7:0] WCTLA_WMASK = 8'hF3;
   localparam logic [7:0] WCTLB_WMASK = 8'hCF;
   localparam logic [7:0] FLAG_MASK  = 8'hE9;
   localparam logic [7:0] DIR_MASK   = 8'h03;
   localparam logic [7:0] REG_RESET  = 8'h00;

   // ==========================================================
   // Encodings and counts
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_CK       = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [1:0] COM_OFF     = 2'h0;
   localparam logic [1:0] COM_TOGGLE  = 2'h1;
   localparam logic [1:0] COM_CLEAR   = 2'h2;
   localparam logic [1:0] COM_SET     = 2'h3;
   localparam logic [1:0] PWM_OFF     = 2'h0;
   localparam logic [1:0] PWM_8       = 2'h1;
   localparam logic [1:0] PWM_9       = 2'h2;
   localparam logic [15:0] TOP_8      = 16'h00FF;
   localparam logic [15:0] TOP_9      = 16'h01FF;
   localparam logic [15:0] TOP_10     = 16'h03FF;
   localparam logic [15:0] WIDE_MAX   = 16'hFFFF;
   localparam logic [7:0]  NARROW_MAX = 8'hFF;
   localparam int PSC_W      = 10;
   localparam int FILTER_LEN = 4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_t;

   typedef struct packed {
      axi_rsp_t rsp;
      logic aw_full; logic w_full; logic [5:0] aw_idx;
      logic [7:0] wbyte; logic wlane;
      logic [PSC_W-1:0] psc;
      logic [2:0] sync1; logic [2:0] sync2; logic [2:0] sync3; logic [2:0] lvl;
      logic [7:0] nctl; logic [7:0] ncnt; logic [7:0] wctl_a; logic [7:0] wctl_b;
      logic [7:0] flags; logic [7:0] mask; logic [7:0] pin_dir; logic [7:0] temp;
      logic [15:0] wcnt; logic [15:0] cmp_a; logic [15:0] cmp_b;
      logic [15:0] act_a; logic [15:0] act_b; logic [15:0] cap;
      logic moved; logic down; logic [FILTER_LEN-1:0] hist; logic cap_cond;
      logic out_a; logic out_b; logic drive_a; logic drive_b;
   } state_t;

endpackage

// *** timer_bus_checker_sva.sv ***
`timescale 1ns/100ps
// ==========================================================
// Register bus checks
module timer_bus_checker
(
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   input  wire timer_pkg::axi_req_t axi_req_i,
   input  wire timer_pkg::axi_rsp_t axi_rsp_o
);
   import timer_pkg::*;
   logic [5:0] rd_idx_reg;
   logic [5:0] rd_idx_next;
   logic       unmapped;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Index of the read in flight, for checks on its data
   always_comb begin
      rd_idx_next = rd_idx_reg;
      if (axi_req_i.arvalid && axi_rsp_o.arready) begin
         rd_idx_next = axi_req_i.araddr[7:2];
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rd_idx_reg <= 6'h00;
      end else begin
         rd_idx_reg <= rd_idx_next;
      end
   end
   assign unmapped = !(rd_idx_reg inside {IDX_CAPTURE_LO, IDX_CAPTURE_HI, IDX_CMP_B_LO,
      IDX_CMP_B_HI, IDX_CMP_A_LO, IDX_CMP_A_HI, IDX_WCNT_LO, IDX_WCNT_HI, IDX_WCTL_B,
      IDX_WCTL_A, IDX_PIN_DIR, IDX_NCNT, IDX_NCTL, IDX_FLAG, IDX_MASK});

   a_wr_answer_time: assert property (
      (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready)
      |-> ##2 axi_rsp_o.bvalid) else $error("write response not two cycles after request");
   a_rd_answer_time: assert property (
      axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
      else $error("read data not one cycle after request");
   a_bresp_held: assert property (
      axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
      else $error("write response dropped before taken");
   a_rdata_held: assert property (
      axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
      else $error("read data dropped before taken");
   a_rdata_byte_wide: assert property (
      axi_rsp_o.rvalid |-> axi_rsp_o.rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_ctl_upper_zero: assert property (
      axi_rsp_o.rvalid && rd_idx_reg == IDX_NCTL |-> axi_rsp_o.rdata[7:3] == 5'h00)
      else $error("narrow control upper bits not zero");
   a_unmapped_error: assert property (
      axi_rsp_o.rvalid && unmapped |-> axi_rsp_o.rresp == RESP_SLVERR
      && axi_rsp_o.rdata == 32'h0000_0000) else $error("unmapped read not refused");
   a_mapped_okay: assert property (
      axi_rsp_o.rvalid && !unmapped |-> axi_rsp_o.rresp == RESP_OKAY)
      else $error("mapped read refused");
   a_one_write_only: assert property (
      axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
      else $error("new write accepted during response");
endmodule // timer_bus_checker

bind dual_timer_counter_unit timer_bus_checker timer_bus_checker_i (
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .axi_req_i(axi_req_i),
   .axi_rsp_o(axi_rsp_o)
);

// *** pin_stimulus.sv ***
`timescale 1ns/100ps
// ==========================================================
// Far side pins: count clocks and capture trigger
module pin_stimulus (
   input  wire logic clk_i,
   output logic      narrow_o,
   output logic      wide_o,
   output logic      capture_o
);
   initial begin
      narrow_o  = 1'b0;
      wide_o    = 1'b0;
      capture_o = 1'b0;
   end

   // Each level held three cycles, one above the two-cycle minimum
   task pulses(input logic wide, input int n);
      repeat (2 * n) begin
         if (wide) begin
            wide_o <= ~wide_o;
         end else begin
            narrow_o <= ~narrow_o;
         end
         repeat (3) @(posedge clk_i);
      end
   endtask

   task level(input logic v, input int hold);
      capture_o <= v;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule // pin_stimulus

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import timer_pkg::*;
   logic     clk_sys_i = 1'b0;
   logic     rst_i     = 1'b1;
   axi_req_t req       = '0;
   axi_rsp_t rsp;
   logic     nclk, wclk, cap, pa, pa_oe, pb, pb_oe;
   logic [7:0] d;
   logic [1:0] r;
   int       errors       = 0;
   int       total_checks = 0;

   always #25 clk_sys_i = ~clk_sys_i;

   dual_timer_counter_unit dual_timer_counter_unit_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
      .narrow_ext_clock_pin_i(nclk), .wide_ext_clock_pin_i(wclk), .capture_pin_i(cap),
      .compare_a_pin_o(pa), .compare_a_pin_oe_o(pa_oe),
      .compare_b_pin_o(pb), .compare_b_pin_oe_o(pb_oe));
   pin_stimulus pin_stimulus_i (.clk_i(clk_sys_i), .narrow_o(nclk), .wide_o(wclk),
      .capture_o(cap));

   // ==========================================================
   // Bus and compare helpers
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [5:0] idx, input logic [7:0] val);
      logic a;
      logic w;
      a = 1'b1;
      w = 1'b1;
      req.awaddr  <= {idx, 2'b00};
      req.wdata   <= {24'h00_0000, val};
      req.wstrb   <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      while (a || w) begin
         @(posedge clk_sys_i);
         if (a && rsp.awready === 1'b1) begin
            req.awvalid <= 1'b0;
            a = 1'b0;
         end
         if (w && rsp.wready === 1'b1) begin
            req.wvalid <= 1'b0;
            w = 1'b0;
         end
      end
      while (rsp.bvalid !== 1'b1) @(posedge clk_sys_i);
      r = rsp.bresp;
      req.bready <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task rd(input logic [5:0] idx);
      req.araddr  <= {idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      do @(posedge clk_sys_i); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      while (rsp.rvalid !== 1'b1) @(posedge clk_sys_i);
      d = rsp.rdata[7:0];
      r = rsp.rresp;
      req.rready <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   // ==========================================================
   // Scenarios
   task t_regs;
      rd(IDX_NCTL);
      chk(d, REG_RESET);
      rd(IDX_WCTL_A);
      chk(d, REG_RESET);
      wr(IDX_NCTL, 8'hFF);
      rd(IDX_NCTL);
      chk(d, NCTL_WMASK);
      wr(IDX_NCTL, 8'(CS_STOP));
      wr(IDX_NCNT, 8'h5A);
      rd(IDX_NCNT);
      chk(d, 8'h5A);
      rd(6'h31);
      chk(8'(r), 8'(RESP_SLVERR));
      wr(6'h31, 8'h00);
      chk(8'(r), 8'(RESP_SLVERR));
      wr(IDX_MASK, 8'hFF);
      rd(IDX_MASK);
      chk(d, FLAG_MASK);
   endtask

   task t_taps;
      int div [5] = '{1, 8, 64, 256, 1024};
      for (int k = 0; k < 5; k++) begin
         wr(IDX_NCNT, 8'h00);
         wr(IDX_NCTL, 8'(CS_CK + k));
         repeat (div[k] * 8) @(posedge clk_sys_i);
         wr(IDX_NCTL, 8'(CS_STOP));
         rd(IDX_NCNT);
         chk(8'(d >= 8'h08 && d <= (k == 0 ? 8'h14 : 8'h0A)), 8'h01);
      end
   endtask

   task t_ext;
      for (int k = 0; k < 2; k++) begin
         wr(IDX_FLAG, 8'hFF);
         rd(IDX_FLAG);
         chk(8'(d[FLAG_NARROW_OVF]), 8'h00);
         wr(IDX_NCNT, 8'hFD);
         wr(IDX_NCTL, 8'(k == 0 ? CS_EXT_FALL : CS_EXT_RISE));
         pin_stimulus_i.pulses(1'b0, 5);
         repeat (6) @(posedge clk_sys_i);
         wr(IDX_NCTL, 8'(CS_STOP));
         rd(IDX_NCNT);
         chk(d, 8'h02);
         rd(IDX_FLAG);
         chk(8'(d[FLAG_NARROW_OVF]), 8'h01);
      end
      wr(IDX_WCTL_B, 8'(CS_STOP));
      wr(IDX_WCNT_HI, 8'h12);
      wr(IDX_WCNT_LO, 8'h34);
      wr(IDX_WCTL_B, 8'(CS_EXT_RISE));
      pin_stimulus_i.pulses(1'b1, 5);
      repeat (6) @(posedge clk_sys_i);
      wr(IDX_WCTL_B, 8'(CS_STOP));
      rd(IDX_WCNT_LO);
      chk(d, 8'h39);
      rd(IDX_WCNT_HI);
      chk(d, 8'h12);
   endtask

   task t_cmp;
      int n;
      logic p;
      wr(IDX_WCNT_HI, 8'h00);
      wr(IDX_WCNT_LO, 8'h00);
      wr(IDX_CMP_A_HI, 8'h00);
      wr(IDX_CMP_A_LO, 8'h10);
      wr(IDX_CMP_B_HI, 8'h00);
      wr(IDX_CMP_B_LO, 8'h08);
      wr(IDX_PIN_DIR, DIR_MASK);
      wr(IDX_WCTL_A, 8'h70);
      wr(IDX_FLAG, 8'hFF);
      wr(IDX_WCTL_B, 8'h09);
      n = 0;
      p = pa;
      repeat (170) begin
         @(posedge clk_sys_i);
         if (pa !== p) n++;
         p = pa;
      end
      chk(8'(n >= 9 && n <= 11), 8'h01);
      chk(8'({pb, pb_oe, pa_oe}), 8'h07);
      wr(IDX_WCTL_B, 8'h08);
      rd(IDX_WCNT_LO);
      chk(8'(d <= 8'h10), 8'h01);
      rd(IDX_FLAG);
      chk({6'h00, d[FLAG_CMP_A], d[FLAG_CMP_B]}, 8'h03);
      wr(IDX_WCTL_A, 8'h60);
      wr(IDX_WCTL_B, 8'h09);
      repeat (40) @(posedge clk_sys_i);
      chk(8'(pb), 8'h00);
      wr(IDX_WCTL_A, 8'h40);
      wr(IDX_PIN_DIR, 8'h00);
      repeat (3) @(posedge clk_sys_i);
      chk(8'({pb_oe, pa_oe}), 8'h00);
      wr(IDX_WCTL_B, 8'(CS_STOP));
   endtask

   task t_cap;
      wr(IDX_WCNT_HI, 8'h0A);
      wr(IDX_WCNT_LO, 8'hBC);
      wr(IDX_WCTL_B, 8'hC0);
      wr(IDX_FLAG, 8'hFF);
      pin_stimulus_i.level(1'b1, 2);
      pin_stimulus_i.level(1'b0, 10);
      rd(IDX_FLAG);
      chk(8'(d[FLAG_CAPTURE]), 8'h00);
      pin_stimulus_i.level(1'b1, 10);
      rd(IDX_FLAG);
      chk(8'(d[FLAG_CAPTURE]), 8'h01);
      rd(IDX_CAPTURE_LO);
      chk(d, 8'hBC);
      rd(IDX_CAPTURE_HI);
      chk(d, 8'h0A);
      wr(IDX_WCTL_B, 8'h00);
      wr(IDX_FLAG, 8'hFF);
      pin_stimulus_i.level(1'b0, 10);
      rd(IDX_FLAG);
      chk(8'(d[FLAG_CAPTURE]), 8'h01);
   endtask

   task t_pwm;
      int n;
      int top;
      wr(IDX_CMP_A_HI, 8'h00);
      wr(IDX_CMP_A_LO, 8'h80);
      wr(IDX_PIN_DIR, 8'h01);
      for (int k = 1; k < 4; k++) begin
         top = (256 << (k - 1)) - 1;
         wr(IDX_WCNT_HI, 8'h00);
         wr(IDX_WCNT_LO, 8'h00);
         wr(IDX_WCTL_A, {COM_CLEAR, COM_OFF, 2'b00, 2'(k)});
         wr(IDX_WCTL_B, 8'(CS_CK));
         repeat (2 * top) @(posedge clk_sys_i);
         n = 0;
         repeat (2 * top) begin
            @(posedge clk_sys_i);
            if (pa === 1'b1) n++;
         end
         chk(8'(n >= 250 && n <= 262), 8'h01);
         wr(IDX_WCTL_B, 8'(CS_STOP));
      end
   endtask

   // ==========================================================
   // Verdict and run control
   task wrap_up;
      if (errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys_i);
      errors++;
      wrap_up;
   end

   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      t_regs;
      t_taps;
      t_ext;
      t_cmp;
      t_cap;
      t_pwm;
      wrap_up;
   end
endmodule // testbench
